/* File: tb/dsm_debug_mux_properties.sv */
// Port checker for the debug mux
`timescale 1ns/1ps
module dsm_debug_mux_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic boot_complete,
  input wire logic auxiliary_pin_two_in,
  input wire logic irq_dbg_oe,
  input wire logic general_output_one_oe,
  input wire logic auxiliary_pin_two_oe,
  input wire logic auxiliary_pin_one_oe,
  input wire logic download_mode
);
  logic en_q;
  logic boot_q;
  logic [3:0] oes;
  // All pin enables together
  assign oes = {irq_dbg_oe, general_output_one_oe, auxiliary_pin_two_oe, auxiliary_pin_one_oe};
  // Enable bit as written over the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_q <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == dsm_pkg::ADDR_CTRL) en_q <= pwdata[0];
  end
  // Boot event seen since reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) boot_q <= 1'b0;
    else if (boot_complete) boot_q <= 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_strap; (auxiliary_pin_two_in && !boot_q) [*4]; endsequence
  property p_ans; psel && penable |-> pready; endproperty
  property p_rdy; pready |-> psel && penable ##1 !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_off; (!en_q) [*3] |-> oes == 4'h0; endproperty
  property p_one; $onehot0(oes); endproperty
  property p_in; !boot_q |-> !auxiliary_pin_two_oe; endproperty
  property p_dl; s_strap |-> ##[0:3] download_mode; endproperty
  property p_stick; download_mode |=> download_mode; endproperty
  a_ans: assert property (p_ans) else $error("no ready in access");
  a_rdy: assert property (p_rdy) else $error("bad ready pulse");
  a_err: assert property (p_err) else $error("error without ready");
  a_off: assert property (p_off) else $error("pin driven while off");
  a_one: assert property (p_one) else $error("two pins driven");
  a_in: assert property (p_in) else $error("strap pin driven early");
  a_dl: assert property (p_dl) else $error("no download mode");
  a_stick: assert property (p_stick) else $error("download lost");
endmodule : dsm_debug_mux_properties
bind dsm_debug_mux dsm_debug_mux_properties dsm_debug_mux_properties_inst (.*);

/* File: tb/dsm_host_model.sv */
// Host side of the strap pin
`timescale 1ns/1ps
module dsm_host_model (
  input wire logic strap_req,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_in
);
  // Pin level: device drive, else host strap
  assign pin_in = pin_oe ? pin_out : strap_req;
endmodule : dsm_host_model

/* File: tb/testbench.sv */
// Self-checking bench for the debug mux
`timescale 1ns/1ps
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, carrier_clk = 0;
  logic data_error = 0, protocol_error = 0, collision = 0, multi_frame_receive = 0;
  logic length_byte_valid = 0, boot_complete = 0, strap = 1, chk = 0, en = 0, dl = 1, dchk = 0;
  logic [15:0] dq[$];
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [7:0] card_sigs = 0, trcv_sigs = 0, rxdata_sigs = 0, length_byte = 0;
  logic [7:0] dac1_source = 0, dac2_source = 0, dac1_out, dac2_out;
  logic pready, pslverr, auxiliary_pin_two_in, download_mode, irq_dbg_out, irq_dbg_oe;
  logic general_output_one_out, general_output_one_oe, auxiliary_pin_two_out;
  logic auxiliary_pin_two_oe, auxiliary_pin_one_out, auxiliary_pin_one_oe;
  logic [32:0] rq[$];
  logic [8:0] pq[$];
  logic [7:0] grp [5] = '{dsm_pkg::GRP_CARD, dsm_pkg::GRP_TRCV, dsm_pkg::GRP_RXDATA,
    dsm_pkg::GRP_RXERR, 8'h01};
  integer seed = 32'h5d4f10f1;
  int n_fail = 0, n_checks = 0;
  dsm_debug_mux dsm_debug_mux_inst (.*);
  dsm_host_model dsm_host_model_inst (.strap_req(strap), .pin_out(auxiliary_pin_two_out),
    .pin_oe(auxiliary_pin_two_oe), .pin_in(auxiliary_pin_two_in));
  always #12.5 pclk = ~pclk;
  task automatic conclude;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic cmp_rd(input logic [32:0] e, input logic [32:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD read exp %h seen %h", e, s);
    end
  endtask : cmp_rd
  task automatic cmp_pin(input logic [8:0] e, input logic [8:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD pins exp %h seen %h", e, s);
    end
  endtask : cmp_pin
  task automatic cmp_dac(input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD dac exp %h seen %h", e, s);
    end
  endtask : cmp_dac
  task automatic dac_chk(input logic [15:0] e);
    dq.push_back(e);
    dchk <= 1'b1;
    @(posedge pclk);
    dchk <= 1'b0;
  endtask : dac_chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic pin_chk(input logic [8:0] e);
    pq.push_back(e);
    chk <= 1'b1;
    @(posedge pclk);
    chk <= 1'b0;
  endtask : pin_chk
  // Expected pins from group, selector and pin
  function automatic logic [8:0] want(input logic [7:0] g, input logic [3:0] s,
    input logic [3:0] p);
    logic [7:0] e;
    logic ok;
    logic v;
    e = {data_error | protocol_error | collision, multi_frame_receive &&
      length_byte > dsm_pkg::LEN_LIMIT, 3'h0, collision, protocol_error, data_error};
    ok = g != dsm_pkg::GRP_RXERR || !(s inside {[4'h3:4'h5]});
    case (g)
      dsm_pkg::GRP_CARD: e = card_sigs;
      dsm_pkg::GRP_TRCV: e = trcv_sigs;
      dsm_pkg::GRP_RXDATA: e = rxdata_sigs;
      dsm_pkg::GRP_RXERR: ;
      default: ok = 1'b0;
    endcase
    v = (s == dsm_pkg::SEL_CARRIER) ? carrier_clk : e[s[2:0]];
    if (!(ok && en && s <= 4'h8 && p < 4'h4)) return {dl, 8'h00};
    return {dl, 4'h8 >> p, v ? 4'h8 >> p : 4'h0};
  endfunction : want
  // Result watcher
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) cmp_rd(rq.pop_front(), {pslverr, prdata});
    if (chk) cmp_pin(pq.pop_front(), {download_mode, irq_dbg_oe, general_output_one_oe,
      auxiliary_pin_two_oe, auxiliary_pin_one_oe, irq_dbg_out & irq_dbg_oe,
      general_output_one_out & general_output_one_oe, auxiliary_pin_two_out &
      auxiliary_pin_two_oe, auxiliary_pin_one_out & auxiliary_pin_one_oe});
    if (dchk) cmp_dac(dq.pop_front(), {dac2_out, dac1_out});
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    pin_chk(9'h100);
    strap <= 1'b0;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    dl = 1'b0;
    pin_chk(9'h000);
    rd(dsm_pkg::ADDR_GROUP, {25'h0, dsm_pkg::GROUP_RST});
    rd(12'h0f0, {1'b1, 32'h0});
    boot_complete <= 1'b1;
    apb(1'b1, dsm_pkg::ADDR_POS, 32'h20);
    apb(1'b1, dsm_pkg::ADDR_GROUP, {24'h0, dsm_pkg::GRP_CARD});
    card_sigs <= 8'hff;
    repeat (5) @(posedge pclk);
    pin_chk(9'h000);
    apb(1'b1, dsm_pkg::ADDR_CTRL, 32'h1);
    en = 1'b1;
    for (int gi = 0; gi < 5; gi++) begin
      for (int s = 0; s < 10; s++) begin
        for (int p = 0; p < 5; p++) begin
          apb(1'b1, dsm_pkg::ADDR_GROUP, {24'h0, grp[gi]});
          apb(1'b1, dsm_pkg::ADDR_POS, {24'h0, p[3:0], s[3:0]});
          multi_frame_receive <= 1'b0;
          @(posedge pclk);
          r = $random(seed);
          {card_sigs, trcv_sigs, rxdata_sigs, carrier_clk, data_error} <= r[25:0];
          {protocol_error, collision, multi_frame_receive} <= r[28:26];
          length_byte <= 8'h1b + {6'h0, r[30:29]};
          {dac1_source, dac2_source} <= r[15:0];
          length_byte_valid <= 1'b1;
          @(posedge pclk);
          length_byte_valid <= 1'b0;
          repeat (5) @(posedge pclk);
          pin_chk(want(grp[gi], s[3:0], p[3:0]));
          dac_chk(16'h0000);
        end
      end
    end
    rd(dsm_pkg::ADDR_POS, 33'h49);
    // Both converters on, then test bus off with a live source
    apb(1'b1, dsm_pkg::ADDR_CTRL, 32'h7);
    repeat (3) @(posedge pclk);
    dac_chk({dac2_source, dac1_source});
    apb(1'b1, dsm_pkg::ADDR_GROUP, {24'h0, dsm_pkg::GRP_CARD});
    apb(1'b1, dsm_pkg::ADDR_POS, 32'h10);
    card_sigs <= 8'hff;
    apb(1'b1, dsm_pkg::ADDR_CTRL, 32'h0);
    en = 1'b0;
    repeat (3) @(posedge pclk);
    pin_chk(9'h000);
    dac_chk(16'h0000);
    conclude();
  end
endmodule : testbench

/* File: verilog/dsm_debug_mux.sv */
// Debug signal multiplexer with boot strap handling and APB registers
//
// Overview of operation
// - First byte picks the signal group
// - No debug output unless test bus enabled
// - Selector 8 gives carrier clock in every group
// - Card group selectors 7 to 4 map flags
// - Card group selectors 3 to 0 map flags
// - Transceive selectors 7 to 4 map controls
// - Transceive selector 3 timeout, 2..0 state bits
// - Receiver data selectors 7 to 4 map processor
// - Selector 3 receive-active, 2 data-arriving status
// - Selector 1 chain reset, 0 bit clock
// - Error group 7 combined, 2 1 0 flags
// - Selector 6 long multi-frame length flag
// - Pin nibble maps four pins, others reserved
// - Pin choice in upper nibble of position
// - Two analog outputs on auxiliary pins
// - Strap pin stays input until boot done
// - Strap high at start-up enters download
// - After boot, strap pin becomes output
`timescale 1ns/1ps
module dsm_debug_mux (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic carrier_clk,
  input wire logic [7:0] card_sigs,
  input wire logic [7:0] trcv_sigs,
  input wire logic [7:0] rxdata_sigs,
  input wire logic data_error,
  input wire logic protocol_error,
  input wire logic collision,
  input wire logic multi_frame_receive,
  input wire logic [7:0] length_byte,
  input wire logic length_byte_valid,
  input wire logic boot_complete,
  input wire logic [7:0] dac1_source,
  input wire logic [7:0] dac2_source,
  input wire logic auxiliary_pin_two_in,
  output logic irq_dbg_out,
  output logic irq_dbg_oe,
  output logic general_output_one_out,
  output logic general_output_one_oe,
  output logic auxiliary_pin_two_out,
  output logic auxiliary_pin_two_oe,
  output logic auxiliary_pin_one_out,
  output logic auxiliary_pin_one_oe,
  output logic [7:0] dac1_out,
  output logic [7:0] dac2_out,
  output logic download_mode
);
  logic testbus_enable_q;
  logic dac1_en_q;
  logic dac2_en_q;
  logic [7:0] group_q;
  logic [7:0] testbus_position_param_q;
  logic boot_done_q;
  logic download_q;
  logic long_len_q;
  logic [1:0] strap_sync_q;
  logic [7:0] card_q;
  logic [7:0] trcv_q;
  logic [7:0] rxdata_q;
  logic [7:0] err_q;
  logic [1:0] carrier_sync_q;
  logic [1:0] boot_sync_q;
  logic sig_value;
  logic sig_valid;
  logic [3:0] sig_sel;
  logic [7:0] grp_bits;
  logic apb_wr;
  logic apb_rd;
  logic [31:0] rd_d;
  logic err_d;
  dsm_sel_if sel_bus ();

  // Two-flop synchronisers for pin and other-domain inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_sync_q <= 2'b00;
      boot_sync_q <= 2'b00;
      strap_sync_q <= 2'b00;
    end else begin
      carrier_sync_q <= {carrier_sync_q[0], carrier_clk};
      boot_sync_q <= {boot_sync_q[0], boot_complete};
      strap_sync_q <= {strap_sync_q[0], auxiliary_pin_two_in};
    end
  end

  // Sampled source signals from the protocol logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_q <= 8'h00;
      trcv_q <= 8'h00;
      rxdata_q <= 8'h00;
      err_q <= 8'h00;
    end else begin
      card_q <= card_sigs;
      trcv_q <= trcv_sigs;
      rxdata_q <= rxdata_sigs;
      err_q <= {(data_error | protocol_error) | collision, long_len_q, 3'b000,
        collision, protocol_error, data_error};
    end
  end

  // Long multi-frame length flag, follows each new length byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      long_len_q <= 1'b0;
    end else if (!multi_frame_receive) begin
      long_len_q <= 1'b0;
    end else if (length_byte_valid) begin
      long_len_q <= (length_byte > dsm_pkg::LEN_LIMIT);
    end
  end

  // Boot tracking and download strap capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_done_q <= 1'b0;
      download_q <= 1'b0;
    end else if (!boot_done_q) begin
      if (strap_sync_q[1]) begin
        download_q <= 1'b1;
      end
      if (boot_sync_q[1]) begin
        boot_done_q <= 1'b1;
      end
    end
  end

  // APB strobes, zero wait state
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  // Control and configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      testbus_enable_q <= 1'b0;
      dac1_en_q <= 1'b0;
      dac2_en_q <= 1'b0;
      group_q <= dsm_pkg::GROUP_RST;
      testbus_position_param_q <= dsm_pkg::POS_RST;
    end else if (apb_wr) begin
      unique case (paddr)
        dsm_pkg::ADDR_CTRL: begin
          testbus_enable_q <= pwdata[0];
          dac1_en_q <= pwdata[1];
          dac2_en_q <= pwdata[2];
        end
        dsm_pkg::ADDR_GROUP: group_q <= pwdata[7:0];
        dsm_pkg::ADDR_POS: testbus_position_param_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data and error decode, prepared in setup cycle
  always_comb begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    unique case (paddr)
      dsm_pkg::ADDR_CTRL: rd_d = {29'h0, dac2_en_q, dac1_en_q, testbus_enable_q};
      dsm_pkg::ADDR_GROUP: rd_d = {24'h0, group_q};
      dsm_pkg::ADDR_POS: rd_d = {24'h0, testbus_position_param_q};
      dsm_pkg::ADDR_STATUS: rd_d = {27'h0, sel_bus.pin_drive != 4'h0, download_q,
        boot_done_q, long_len_q, sig_valid};
      dsm_pkg::ADDR_DAC: rd_d = {16'h0, dac2_out, dac1_out};
      default: err_d = 1'b1;
    endcase
  end

  // APB answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && err_d;
      if (apb_rd) begin
        prdata <= rd_d;
      end
    end
  end

  // Group selection of the eight test bus bits
  always_comb begin
    grp_bits = 8'h00;
    sig_valid = 1'b1;
    unique case (group_q)
      dsm_pkg::GRP_CARD: grp_bits = card_q;
      dsm_pkg::GRP_TRCV: grp_bits = trcv_q;
      dsm_pkg::GRP_RXDATA: grp_bits = rxdata_q;
      dsm_pkg::GRP_RXERR: grp_bits = err_q;
      default: sig_valid = 1'b0;
    endcase
  end

  // Signal selection within the group
  assign sig_sel = testbus_position_param_q[dsm_pkg::POS_SIG_LSB +: 4];
  always_comb begin
    sig_value = 1'b0;
    if (sig_sel == dsm_pkg::SEL_CARRIER) begin
      sig_value = carrier_sync_q[1];
    end else if (sig_sel < dsm_pkg::SEL_CARRIER) begin
      sig_value = grp_bits[sig_sel[2:0]];
    end
  end

  // Reserved selectors also leave the pin undriven
  assign sel_bus.enable = testbus_enable_q;
  assign sel_bus.sig_valid = sig_valid && (sig_sel <= dsm_pkg::SEL_CARRIER) &&
    !(group_q == dsm_pkg::GRP_RXERR && sig_sel >= 4'h3 && sig_sel <= 4'h5);
  assign sel_bus.sig_value = sig_value;
  assign sel_bus.pin_sel = testbus_position_param_q[dsm_pkg::POS_PIN_LSB +: 4];

  dsm_pin_router u_router (
    .sel(sel_bus.router)
  );

  // Registered pin drivers; strap pin held as input before boot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_dbg_out <= 1'b0;
      irq_dbg_oe <= 1'b0;
      general_output_one_out <= 1'b0;
      general_output_one_oe <= 1'b0;
      auxiliary_pin_two_out <= 1'b0;
      auxiliary_pin_two_oe <= 1'b0;
      auxiliary_pin_one_out <= 1'b0;
      auxiliary_pin_one_oe <= 1'b0;
    end else begin
      irq_dbg_oe <= sel_bus.pin_drive[0];
      irq_dbg_out <= sel_bus.pin_drive[0] && sig_value;
      general_output_one_oe <= sel_bus.pin_drive[1];
      general_output_one_out <= sel_bus.pin_drive[1] && sig_value;
      auxiliary_pin_two_oe <= boot_done_q && sel_bus.pin_drive[2];
      auxiliary_pin_two_out <= boot_done_q && sel_bus.pin_drive[2] && sig_value;
      auxiliary_pin_one_oe <= sel_bus.pin_drive[3];
      auxiliary_pin_one_out <= sel_bus.pin_drive[3] && sig_value;
    end
  end

  // Analog converter codes and download state output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac1_out <= 8'h00;
      dac2_out <= 8'h00;
      download_mode <= 1'b0;
    end else begin
      dac1_out <= (testbus_enable_q && dac1_en_q) ? dac1_source : 8'h00;
      dac2_out <= (testbus_enable_q && dac2_en_q && boot_done_q) ? dac2_source : 8'h00;
      download_mode <= download_q;
    end
  end
endmodule : dsm_debug_mux

/* File: verilog/dsm_pin_router.sv */
// Routes the chosen debug signal onto one of the four debug pins
`timescale 1ns/1ps
module dsm_pin_router (
  dsm_sel_if.router sel
);
  // One-hot pin drive, none for reserved codes or disabled bus
  always_comb begin
    sel.pin_drive = 4'h0;
    if (sel.enable && sel.sig_valid) begin
      unique case (sel.pin_sel)
        dsm_pkg::PIN_IRQ: sel.pin_drive[0] = 1'b1;
        dsm_pkg::PIN_GPO: sel.pin_drive[1] = 1'b1;
        dsm_pkg::PIN_AUXILIARY_PIN_TWO: sel.pin_drive[2] = 1'b1;
        dsm_pkg::PIN_AUXILIARY_PIN_ONE: sel.pin_drive[3] = 1'b1;
        default: sel.pin_drive = 4'h0;
      endcase
    end
  end
endmodule : dsm_pin_router

/* File: verilog/dsm_pkg.sv */
// Package with constants for the debug signal multiplexer and boot strap
package dsm_pkg;
  // Group codes
  localparam logic [7:0] GRP_CARD = 8'h30;
  localparam logic [7:0] GRP_TRCV = 8'h58;
  localparam logic [7:0] GRP_RXDATA = 8'h70;
  localparam logic [7:0] GRP_RXERR = 8'h73;
  // Selector codes
  localparam logic [3:0] SEL_CARRIER = 4'h8;
  // Pin-select codes
  localparam logic [3:0] PIN_IRQ = 4'h0;
  localparam logic [3:0] PIN_GPO = 4'h1;
  localparam logic [3:0] PIN_AUXILIARY_PIN_TWO = 4'h2;
  localparam logic [3:0] PIN_AUXILIARY_PIN_ONE = 4'h3;
  // Field positions of the position parameter
  localparam int POS_PIN_LSB = 4;
  localparam int POS_SIG_LSB = 0;
  // Length threshold for multi-frame reception
  localparam logic [7:0] LEN_LIMIT = 8'h1c;
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_GROUP = 12'h004;
  localparam logic [11:0] ADDR_POS = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_DAC = 12'h010;
  // Reset values, pin count and converter width
  localparam logic [7:0] GROUP_RST = 8'h00;
  localparam logic [7:0] POS_RST = 8'h00;
  localparam int PIN_COUNT = 4;
  localparam int DAC_W = 8;
endpackage : dsm_pkg

/* File: verilog/dsm_sel_if.sv */
// Interface carrying the selection between top and pin router
`timescale 1ns/1ps
interface dsm_sel_if;
  logic enable;
  logic sig_valid;
  logic sig_value;
  logic [3:0] pin_sel;
  logic [3:0] pin_drive;
  modport src (output enable, output sig_valid, output sig_value, output pin_sel,
    input pin_drive);
  modport router (input enable, input sig_valid, input sig_value, input pin_sel,
    output pin_drive);
endinterface : dsm_sel_if
